// File: hw/wdr_pkg.sv
// Package for the watchdog and reset control block: constants and carried types
package wdr_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS       = 10;
  // Input filter limits
  localparam int SPIKE_NS            = 50;
  localparam int VALID_NS            = 500;
  localparam int SPIKE_CYC           = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VALID_CYC           = VALID_NS / CLK_PERIOD_NS;
  // Half clock periods, one cycle of clk counts as two
  localparam int HCP_MIN_PULSE       = 4;
  localparam int HCP_SEQ             = 1024;
  localparam int HCP_EXTRA           = 12;
  localparam int HCP_SAMPLE_GAP      = 8;
  localparam int HCP_LONG_BASE       = 1032;
  localparam int SEQ_CYC             = (HCP_SEQ + HCP_EXTRA + HCP_MIN_PULSE) / 2;
  localparam int SAMPLE_CYC          = SEQ_CYC + HCP_SAMPLE_GAP / 2;
  // External boot release delay, 3 to 8 half periods
  localparam int HCP_EXT_RELEASE     = 6;
  localparam int EXT_RELEASE_CYC     = HCP_EXT_RELEASE / 2;
  // Flash initialization bound
  localparam int FLASH_INIT_US       = 1000;
  localparam int FLASH_INIT_CYC      = FLASH_INIT_US * 1000 / CLK_PERIOD_NS;
  localparam int FLASH_EARLY_CYC     = 16;
  localparam logic [15:0] FLASH_EARLY_WORD = 16'hFFFF;
  localparam logic [15:0] FLASH_LATE_WORD  = 16'h009B;
  // Watchdog
  localparam int WDT_WIDTH           = 16;
  localparam int PRESC_SLOW          = 128;
  localparam int PRESC_FAST          = 2;
  localparam logic [7:0] RELOAD_RST  = 8'h00;

  // Register indices
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_COUNT  = 4'h1;
  localparam logic [3:0] ADDR_CMD    = 4'h2;
  localparam logic [3:0] ADDR_SYS    = 4'h3;
  // Control register fields
  localparam int CTRL_PRESC          = 0;
  localparam int CTRL_EN             = 1;
  localparam int CTRL_WDT_F          = 2;
  localparam int CTRL_SW_F           = 3;
  localparam int CTRL_SHORT_F        = 4;
  localparam int CTRL_LONG_F         = 5;
  localparam int CTRL_PON_F          = 6;
  localparam int CTRL_RELOAD         = 8;
  // Command register bits
  localparam int CMD_SERVICE         = 0;
  localparam int CMD_SWRESET         = 1;
  localparam int CMD_END_OF_INIT_INSTRUCTION           = 2;
  localparam int CMD_DISABLE         = 3;
  // System config bit
  localparam int SYS_BIDIR           = 3;

  // Reset source flags
  typedef struct packed {
    logic pon;
    logic long_hw;
    logic short_hw;
    logic sw;
    logic wdt;
  } wdr_flags_t;

  // Reset sequencer states, Gray along the main path
  typedef enum logic [2:0] {
    WDR_RUN   = 3'b000,
    WDR_SEQ   = 3'b001,
    WDR_HOLD  = 3'b011,
    WDR_FLASH = 3'b010,
    WDR_ASYNC = 3'b110
  } wdr_state_t;

endpackage

// File: hw/wdr_ctrl.sv
// Watchdog timer and system reset source control
`timescale 1ns/10ps
`default_nettype none

module wdr_ctrl #(
  parameter int FLASH_INIT_CYCLES = wdr_pkg::FLASH_INIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        reset_input_pin,
  input  wire logic        reset_mode_select_pin,
  input  wire logic        external_access_pin,
  input  wire logic        flash_init_done,
  output logic             reset_output_pin,
  output logic             reset_input_pin_out,
  output logic             reset_input_pin_oe,
  output logic             internal_reset,
  output logic             port0_pullup,
  output logic             bus_hiz,
  output logic             flash_gate,
  output logic      [15:0] flash_gate_word
);

  // Filter span; sequence counter also covers the flash timeout
  localparam int FW = $clog2(wdr_pkg::VALID_CYC + 1);
  localparam int SW = $clog2(FLASH_INIT_CYCLES + wdr_pkg::SAMPLE_CYC + 1);

  // Sequencer, filter and watchdog state
  wdr_pkg::wdr_state_t state;
  wdr_pkg::wdr_flags_t flags;
  logic [FW-1:0]  low_cnt;
  logic           filt_low;
  logic [SW-1:0]  seq_cnt;
  logic [15:0]    wdt_cnt;
  logic [6:0]     presc;
  logic [7:0]     reload;
  logic           presc_sel;
  logic           wdt_en;
  logic           init_done;
  logic           bidir_en;
  logic           seq_hw;
  logic           drive_pin;
  logic           flash_ready;
  logic [SW-1:0]  flash_cnt;

  // Decoded strobes and requests
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_sys;
  logic svc;
  logic sw_req;
  logic tick;
  logic wdt_ovf;
  logic async_req;
  logic sync_req;
  assign wr_ctrl   = reg_wr && reg_addr == wdr_pkg::ADDR_CTRL;
  assign wr_cmd    = reg_wr && reg_addr == wdr_pkg::ADDR_CMD;
  assign wr_sys    = reg_wr && reg_addr == wdr_pkg::ADDR_SYS;
  assign svc       = wr_cmd && reg_wdata[wdr_pkg::CMD_SERVICE];
  assign sw_req    = wr_cmd && reg_wdata[wdr_pkg::CMD_SWRESET] && state == wdr_pkg::WDR_RUN;
  assign tick      = presc_sel ? (presc == 7'(wdr_pkg::PRESC_SLOW - 1))
                               : presc[0] == 1'(wdr_pkg::PRESC_FAST - 1);
  assign wdt_ovf   = wdt_en && tick && wdt_cnt == 16'hFFFF && state == wdr_pkg::WDR_RUN;
  assign async_req = filt_low && !reset_mode_select_pin && state != wdr_pkg::WDR_ASYNC;
  assign sync_req  = filt_low && reset_mode_select_pin && state == wdr_pkg::WDR_RUN;

  // Input filter: low must persist before it counts, spikes never reach the sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_cnt  <= '0;
      filt_low <= 1'b1;
    end else if (reset_input_pin) begin
      low_cnt  <= '0;
      filt_low <= 1'b0;
    end else if (low_cnt != FW'(wdr_pkg::VALID_CYC)) begin
      low_cnt  <= low_cnt + 1'b1;
    end else begin
      filt_low <= 1'b1;
    end
  end

  // Reset sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state   <= wdr_pkg::WDR_ASYNC;
      seq_cnt <= '0;
      seq_hw  <= 1'b0;
    end else if (async_req) begin
      state   <= wdr_pkg::WDR_ASYNC;
      seq_cnt <= '0;
    end else begin
      unique case (state)
        wdr_pkg::WDR_RUN: begin
          seq_cnt <= '0;
          seq_hw  <= sync_req;
          if (sync_req || sw_req || wdt_ovf) state <= wdr_pkg::WDR_SEQ;
        end
        wdr_pkg::WDR_SEQ: begin
          seq_cnt <= seq_cnt + 1'b1;
          if (seq_cnt == SW'(wdr_pkg::SAMPLE_CYC - 1)) state <= wdr_pkg::WDR_HOLD;
        end
        wdr_pkg::WDR_HOLD, wdr_pkg::WDR_ASYNC: begin
          seq_cnt <= '0;
          if (!filt_low) state <= wdr_pkg::WDR_FLASH;
        end
        wdr_pkg::WDR_FLASH: begin
          seq_cnt <= seq_cnt + 1'b1;
          // Entry and the registered output each add a cycle, so leave two counts early
          if (external_access_pin ? flash_ready
              : seq_cnt == SW'(wdr_pkg::EXT_RELEASE_CYC - 2))
            state <= wdr_pkg::WDR_RUN;
        end
        default: state <= wdr_pkg::WDR_ASYNC;
      endcase
    end
  end

  // Flash initialization tracker; restarts on each reset, bounded by a timeout
  always_ff @(posedge clk) begin
    if (!resetn || state == wdr_pkg::WDR_ASYNC || state == wdr_pkg::WDR_SEQ) begin
      flash_cnt   <= '0;
      flash_ready <= 1'b0;
    end else if (!flash_ready) begin
      flash_cnt   <= flash_cnt + 1'b1;
      flash_ready <= flash_init_done || flash_cnt == SW'(FLASH_INIT_CYCLES - 1);
    end
  end

  // Reset source flags; set beats a simultaneous end-of-init clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flags <= '{pon: 1'b1, default: 1'b0};
    end else begin
      // Later assignments win, so any set outranks the end-of-init clear
      if (wr_cmd && reg_wdata[wdr_pkg::CMD_END_OF_INIT_INSTRUCTION] && !init_done)
        flags <= '0;
      if (async_req && state == wdr_pkg::WDR_RUN)
        flags <= '0;
      if (state == wdr_pkg::WDR_RUN && (sw_req || wdt_ovf) && !sync_req) begin
        flags     <= '0;
        flags.wdt <= wdt_ovf;
        flags.sw  <= sw_req && !wdt_ovf;
      end
      if (state == wdr_pkg::WDR_SEQ && seq_cnt == SW'(wdr_pkg::SAMPLE_CYC - 1) && seq_hw) begin
        flags          <= '0;
        flags.short_hw <= 1'b1;
        flags.long_hw  <= filt_low;
      end
    end
  end

  // Watchdog control: enable, prescaler, reload, end-of-init lock
  always_ff @(posedge clk) begin
    if (!resetn || state != wdr_pkg::WDR_RUN) begin
      wdt_en    <= 1'b1;
      init_done <= 1'b0;
      presc_sel <= 1'b0;
      reload    <= wdr_pkg::RELOAD_RST;
    end else begin
      if (wr_ctrl) begin
        presc_sel <= reg_wdata[wdr_pkg::CTRL_PRESC];
        reload    <= reg_wdata[wdr_pkg::CTRL_RELOAD +: 8];
      end
      if (wr_cmd && reg_wdata[wdr_pkg::CMD_DISABLE] && !init_done)
        wdt_en <= 1'b0;
      if (wr_cmd && reg_wdata[wdr_pkg::CMD_END_OF_INIT_INSTRUCTION])
        init_done <= 1'b1;
    end
  end

  // Prescaler and counter; slow setting covers 00h reload to the longest timeout
  always_ff @(posedge clk) begin
    if (!resetn || state != wdr_pkg::WDR_RUN) begin
      presc   <= '0;
      wdt_cnt <= '0;
    end else begin
      presc <= presc + 1'b1;
      if (svc)
        wdt_cnt <= {reload, 8'h00};
      else if (wdt_en && tick)
        wdt_cnt <= wdt_cnt + 1'b1;
    end
  end

  // System config: bidirectional enable cleared by every reset sequence
  always_ff @(posedge clk) begin
    if (!resetn || state != wdr_pkg::WDR_RUN)
      bidir_en <= 1'b0;
    else if (wr_sys)
      bidir_en <= reg_wdata[wdr_pkg::SYS_BIDIR];
  end

  // Pin drive during sequence; mode pin low blocks it for soft sources
  always_ff @(posedge clk) begin
    if (!resetn)
      drive_pin <= 1'b0;
    else if (state == wdr_pkg::WDR_RUN)
      drive_pin <= bidir_en && (sw_req || wdt_ovf || sync_req)
                   && (reset_mode_select_pin || sync_req);
    else if (state != wdr_pkg::WDR_SEQ)
      drive_pin <= 1'b0;
  end

  // Outputs, all registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reset_output_pin <= 1'b0;
      internal_reset   <= 1'b1;
      port0_pullup     <= 1'b1;
      bus_hiz          <= 1'b1;
    end else begin
      reset_output_pin <= state == wdr_pkg::WDR_RUN && !async_req && !sync_req
                          && !sw_req && !wdt_ovf;
      internal_reset   <= state != wdr_pkg::WDR_RUN || async_req || sync_req;
      port0_pullup     <= state == wdr_pkg::WDR_ASYNC || async_req;
      bus_hiz          <= state != wdr_pkg::WDR_RUN || async_req;
    end
  end
  // Open-drain pin: value held low, only the enable moves
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reset_input_pin_out <= 1'b0;
      reset_input_pin_oe  <= 1'b0;
    end else begin
      reset_input_pin_out <= 1'b0;
      reset_input_pin_oe  <= drive_pin;
    end
  end

  // Flash read gate: early word, then the late word until init completes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flash_gate      <= 1'b1;
      flash_gate_word <= wdr_pkg::FLASH_EARLY_WORD;
    end else begin
      flash_gate      <= !flash_ready;
      flash_gate_word <= flash_cnt < SW'(wdr_pkg::FLASH_EARLY_CYC) ? wdr_pkg::FLASH_EARLY_WORD
                                                                   : wdr_pkg::FLASH_LATE_WORD;
    end
  end

  // Register read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        wdr_pkg::ADDR_CTRL:  reg_rdata <= {reload, 1'b0, flags.pon, flags.long_hw,
                                           flags.short_hw, flags.sw, flags.wdt, wdt_en, presc_sel};
        wdr_pkg::ADDR_COUNT: reg_rdata <= wdt_cnt;
        wdr_pkg::ADDR_SYS:   reg_rdata <= {12'h000, bidir_en, 3'h0};
        default:             reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Checks
  a_ovf_resets: assert property (@(posedge clk) disable iff (!resetn)
    wdt_ovf |=> state == wdr_pkg::WDR_SEQ ##1 !reset_output_pin)
    else $error("overflow did not start reset");
  a_en_after_seq: assert property (@(posedge clk) disable iff (!resetn)
    $fell(internal_reset) |-> wdt_en && !bidir_en)
    else $error("watchdog not enabled after reset");
  a_reload_load: assert property (@(posedge clk) disable iff (!resetn)
    svc && state == wdr_pkg::WDR_RUN && !async_req |=> wdt_cnt[15:8] == $past(reload))
    else $error("reload not applied");
  a_async_entry: assert property (@(posedge clk) disable iff (!resetn)
    async_req |=> state == wdr_pkg::WDR_ASYNC && port0_pullup && !reset_output_pin)
    else $error("async reset not entered");
  a_seq_length: assert property (@(posedge clk) disable iff (!resetn)
    state == wdr_pkg::WDR_RUN && sync_req |=> state == wdr_pkg::WDR_SEQ [*8])
    else $error("sequence cut short");
  a_spike_reject: assert property (@(posedge clk) disable iff (!resetn)
    $fell(reset_input_pin) && !filt_low |=> !filt_low [*4])
    else $error("spike passed filter");
  a_ext_release: assert property (@(posedge clk) disable iff (!resetn)
    state == wdr_pkg::WDR_FLASH && !external_access_pin && !async_req
      |-> ##[1:4] state == wdr_pkg::WDR_RUN)
    else $error("external boot release late");
  a_flash_gate: assert property (@(posedge clk) disable iff (!resetn)
    !flash_ready |=> flash_gate)
    else $error("flash not gated");
  a_end_of_init_instruction_clear: assert property (@(posedge clk) disable iff (!resetn)
    wr_cmd && reg_wdata[wdr_pkg::CMD_END_OF_INIT_INSTRUCTION] && !init_done && state == wdr_pkg::WDR_RUN
      && !sw_req && !wdt_ovf && !async_req |=> flags == '0)
    else $error("flags not cleared");
  a_mode_block: assert property (@(posedge clk) disable iff (!resetn)
    state == wdr_pkg::WDR_RUN && !reset_mode_select_pin && !filt_low |=> !drive_pin)
    else $error("pin driven with mode low");

  // Counter, flag, filter, bidirectional enable and pin checks
  a_count_step: assert property (@(posedge clk) disable iff (!resetn)
    state == wdr_pkg::WDR_RUN && !async_req && !svc && wdt_en && tick
      |=> wdt_cnt == $past(wdt_cnt) + 16'h0001)
    else $error("counter did not advance");
  a_sw_flag: assert property (@(posedge clk) disable iff (!resetn)
    sw_req && !wdt_ovf && !sync_req && !async_req |=> flags.sw && !flags.wdt)
    else $error("software reset not flagged");
  a_long_flag: assert property (@(posedge clk) disable iff (!resetn)
    state == wdr_pkg::WDR_SEQ && seq_cnt == SW'(wdr_pkg::SAMPLE_CYC - 1) && seq_hw
      |=> flags.short_hw && flags.long_hw == $past(filt_low))
    else $error("warm reset not classified");
  a_filter_accept: assert property (@(posedge clk) disable iff (!resetn)
    !reset_input_pin && low_cnt == FW'(wdr_pkg::VALID_CYC) |=> filt_low)
    else $error("long low not accepted");
  a_bidir_clear: assert property (@(posedge clk) disable iff (!resetn)
    state != wdr_pkg::WDR_RUN |=> !bidir_en)
    else $error("bidirectional enable kept");
  a_pin_drive: assert property (@(posedge clk) disable iff (!resetn)
    sw_req && bidir_en && reset_mode_select_pin |=> drive_pin)
    else $error("reset pin not driven");

endmodule

`default_nettype wire

// File: verification/wdr_board.sv
// Board reset circuitry model: reset wire with pull-up, mode and boot pins, flash ready
`timescale 1ns/10ps
`default_nettype none
module wdr_board (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output wire logic reset_input_pin,
  output var  logic reset_mode_select_pin,
  output var  logic external_access_pin,
  output wire logic flash_init_done
);
  logic drive_low;
  int   done_cnt;

  // Board holds reset and mode low from power-up until the bench lets go
  initial begin
    drive_low = 1'b1;
    reset_mode_select_pin = 1'b0;
    external_access_pin = 1'b1;
    done_cnt = 0;
  end

  // Open-drain wire with pull-up: any party pulling low wins
  assign reset_input_pin = (drive_low || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;

  // Flash restarts its own init whenever the reset wire is low
  always @(posedge clk) begin
    if (!reset_input_pin) done_cnt <= 0;
    else if (done_cnt < 40) done_cnt <= done_cnt + 1;
  end
  assign flash_init_done = (done_cnt >= 40);

  // Pin changes land just after a clock edge
  task automatic set_pins(input logic mode, input logic ext);
    @(posedge clk);
    reset_mode_select_pin <= mode;
    external_access_pin <= ext;
  endtask

  task automatic hold_low(input int n);
    @(posedge clk);
    drive_low <= 1'b1;
    repeat (n) @(posedge clk);
    drive_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verification/wdr_ctrl_tb_top.sv
// Self-checking bench for the watchdog and reset control block
`timescale 1ns/10ps
`default_nettype none
module wdr_ctrl_tb_top;
  logic        clk;
  logic        resetn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        rst_in, mode_pin, ext_pin, fl_done, rst_out, pin_out, pin_oe;
  logic        int_rst, p0_up, hiz, fgate;
  logic [15:0] fword;
  logic [15:0] d;
  int          n_mismatch = 0;
  int          n_compared = 0;

  // Short flash init bound keeps the run brief
  wdr_ctrl #(.FLASH_INIT_CYCLES(200)) dut (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reset_input_pin(rst_in), .reset_mode_select_pin(mode_pin),
    .external_access_pin(ext_pin), .flash_init_done(fl_done),
    .reset_output_pin(rst_out), .reset_input_pin_out(pin_out),
    .reset_input_pin_oe(pin_oe), .internal_reset(int_rst), .port0_pullup(p0_up),
    .bus_hiz(hiz), .flash_gate(fgate), .flash_gate_word(fword));

  wdr_board brd (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .reset_input_pin(rst_in),
    .reset_mode_select_pin(mode_pin), .external_access_pin(ext_pin),
    .flash_init_done(fl_done));

  // 100 MHz clock
  always #5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Register bus: one-cycle strobes, read data taken in the following cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded wait on reset output (w=0) or internal reset (w=1); a hang ends the run
  task automatic wait_on(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (((w == 0) ? rst_out : int_rst) !== v) begin
      @(posedge clk);
      #1 n++;
      if (n > lim) begin
        n_mismatch++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, ~v, v);
        stop_test();
      end
    end
  endtask

  // Wait for the core to run again, check source flags and enable, then end init
  task automatic recover(input logic [15:0] exp);
    int n;
    wait_on(1, 1'b0, 3000, n);
    wait_on(0, 1'b1, 3000, n);
    rd(wdr_pkg::ADDR_CTRL, d);
    chk(d & 16'h007E, exp);
    wr(wdr_pkg::ADDR_CMD, 16'h0004);
    rd(wdr_pkg::ADDR_CTRL, d);
    chk(d & 16'h007C, 16'h0000);
  endtask

  task automatic t_power;
    brd.hold_low(20);
    repeat (3) @(posedge clk);
    #1 chk(fword, wdr_pkg::FLASH_EARLY_WORD);
    repeat (27) @(posedge clk);
    #1 chk(fword, wdr_pkg::FLASH_LATE_WORD);
    chk({15'h0, fgate}, 16'h0001);
    chk({15'h0, int_rst}, 16'h0001);
    recover(16'h0042);
    chk({15'h0, fgate}, 16'h0000);
    wr(wdr_pkg::ADDR_CMD, 16'h0008);
    rd(wdr_pkg::ADDR_CTRL, d);
    chk(d & 16'h0002, 16'h0002);
    rd(4'h7, d);
    chk(d, 16'h0000);
    $display("power-on test done");
  endtask

  task automatic t_watchdog;
    int n;
    wr(wdr_pkg::ADDR_CTRL, 16'hFF00);
    wr(wdr_pkg::ADDR_CMD, 16'h0001);
    rd(wdr_pkg::ADDR_COUNT, d);
    chk(d & 16'hFF00, 16'hFF00);
    wait_on(0, 1'b0, 600, n);
    chk(16'(n >= 505 && n <= 520), 16'h0001);
    recover(16'h0006);
    $display("watchdog test done");
  endtask

  task automatic t_presc;
    wr(wdr_pkg::ADDR_CTRL, 16'hFF01);
    wr(wdr_pkg::ADDR_CMD, 16'h0001);
    repeat (300) @(posedge clk);
    rd(wdr_pkg::ADDR_COUNT, d);
    chk(d & 16'hFFFC, 16'hFF00);
    $display("prescaler test done");
  endtask

  // Disable before end of init is honoured
  task automatic t_sw;
    int n;
    wr(wdr_pkg::ADDR_CMD, 16'h0002);
    wait_on(0, 1'b0, 10, n);
    wait_on(1, 1'b0, 3000, n);
    wr(wdr_pkg::ADDR_CMD, 16'h0008);
    recover(16'h0008);
    $display("software reset test done");
  endtask

  task automatic t_bidir;
    int n;
    logic saw;
    for (int m = 0; m < 2; m++) begin
      brd.set_pins(m[0], 1'b1);
      wr(wdr_pkg::ADDR_SYS, 16'h0008);
      wr(wdr_pkg::ADDR_CMD, 16'h0002);
      saw = 1'b0;
      repeat (600) begin
        @(posedge clk);
        #1 saw = saw | pin_oe;
      end
      chk({15'h0, saw}, 16'(m));
      wait_on(1, 1'b0, 3000, n);
      rd(wdr_pkg::ADDR_SYS, d);
      chk(d & 16'h0008, 16'h0000);
    end
    $display("bidirectional test done");
  endtask

  // A 40 ns spike must not start a reset
  task automatic t_spike;
    logic saw;
    saw = 1'b0;
    brd.hold_low(4);
    repeat (100) begin
      @(posedge clk);
      #1 saw = saw | ~rst_out;
    end
    chk({15'h0, saw}, 16'h0000);
    $display("spike test done");
  endtask

  task automatic t_warm;
    brd.hold_low(60);
    recover(16'h0012);
    brd.hold_low(700);
    recover(16'h0032);
    $display("warm reset test done");
  endtask

  task automatic t_async;
    int n;
    brd.set_pins(1'b0, 1'b0);
    fork
      brd.hold_low(60);
      begin
        repeat (57) @(posedge clk);
        #1 chk({12'h0, rst_out, p0_up, hiz, int_rst}, 16'h0007);
      end
    join
    wait_on(1, 1'b0, 50, n);
    chk(16'(n >= 3 && n <= 5), 16'h0001);
    wr(wdr_pkg::ADDR_CMD, 16'h0004);
    $display("async reset test done");
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_power();
    t_watchdog();
    t_presc();
    t_sw();
    t_bidir();
    brd.set_pins(1'b1, 1'b1);
    t_spike();
    t_warm();
    t_async();
    stop_test();
  end
endmodule
`default_nettype wire
